/* File: rtl/awo_add_stage.sv */
// execute stage for the trapping and non-trapping signed word add
// What this block does, and what it trusts its issuer to do
// RULE1 - decode opcode 000000, function 100000, field indices
// RULE2 - issuer keeps bits 10..6 zero
// RULE3 - add the two 32-bit source words
// RULE4 - overflow when bit 32 differs from 31
// RULE5 - overflow: keep destination, raise exception
// RULE6 - otherwise write sign-extended sum to destination
// RULE7 - issuer supplies properly sign-extended source words
// RULE8 - non-trapping variant never raises overflow
// RULE9 - register zero reads zero, ignores writes
// RULE10 - exception and suppressed write share cycle, cause
`timescale 1ns/1ps
`include "awo_map.svh"
module awo_add_stage #(
  parameter int XLEN = 64
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [32*XLEN-1:0] regImage,
  output logic writeEnable,
  output awo_pkg::awo_index_t writeIndex,
  output logic [XLEN-1:0] writeData,
  output logic overflowTrap,
  output awo_pkg::awo_cause_t trapCause,
  output logic retired
);
  logic rstMeta_q, rstSync_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  awo_regread_if #(.XLEN(XLEN)) rd ();
  awo_read_port #(.XLEN(XLEN)) u_read (
    .regImage(regImage),
    .rd(rd)
  );

  // one decode for both variants so the two can never disagree on the opcode test
  function automatic logic funIs(input logic [31:0] w, input logic [5:0] code);
    logic opcOk;
    logic funOk;
    opcOk = w[`AWO_OPC_HI:`AWO_OPC_LO] == `AWO_OPC_REGFMT; // [RULE1]
    funOk = w[`AWO_FUN_HI:`AWO_FUN_LO] == code;
    funIs = opcOk && funOk;
  endfunction

  logic isRegFmt, isTrapAdd, isPlainAdd;
  awo_pkg::awo_index_t dstIndex;
  logic [32:0] wideSum;
  logic overflow;
  always_comb begin
    isRegFmt = instrWord[`AWO_OPC_HI:`AWO_OPC_LO] == `AWO_OPC_REGFMT; // [RULE1]
    isTrapAdd = funIs(instrWord, `AWO_FUN_TRAP_ADD);
    isPlainAdd = funIs(instrWord, `AWO_FUN_PLAIN_ADD);
    rd.firstSourceIndex = instrWord[`AWO_SRC1_HI:`AWO_SRC1_LO];
    rd.secondSourceIndex = instrWord[`AWO_SRC2_HI:`AWO_SRC2_LO];
    dstIndex = instrWord[`AWO_DST_HI:`AWO_DST_LO];
    // bits 10..6 and upper source bits are trusted, not checked [RULE2] [RULE7]
    wideSum = {rd.firstValue[`AWO_WORD_SIGN], rd.firstValue[31:0]}
            + {rd.secondValue[`AWO_WORD_SIGN], rd.secondValue[31:0]}; // [RULE3]
    overflow = wideSum[`AWO_CARRY_BIT] != wideSum[`AWO_WORD_SIGN]; // [RULE4]
  end

  logic writeEnable_d, overflowTrap_d, retired_d;
  logic [XLEN-1:0] writeData_d;
  awo_pkg::awo_index_t writeIndex_d;
  awo_pkg::awo_cause_t trapCause_d;
  always_comb begin
    writeEnable_d = 1'b0;
    overflowTrap_d = 1'b0;
    retired_d = 1'b0;
    writeIndex_d = dstIndex;
    writeData_d = {{(XLEN-32){wideSum[`AWO_WORD_SIGN]}}, wideSum[31:0]}; // [RULE6]
    trapCause_d = '0;
    if (instrValid && isTrapAdd && overflow) begin
      overflowTrap_d = 1'b1; // [RULE5]
      trapCause_d = `AWO_CAUSE_OVERFLOW; // [RULE10]
    end else if (instrValid && (isTrapAdd || isPlainAdd)) begin
      // plain variant lands here even on overflow [RULE8]
      writeEnable_d = dstIndex != `AWO_ZERO_INDEX; // [RULE9]
      retired_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      writeEnable <= 1'b0;
      writeIndex <= '0;
      writeData <= '0;
      overflowTrap <= 1'b0;
      trapCause <= '0;
      retired <= 1'b0;
    end else if (enable) begin
      writeEnable <= writeEnable_d;
      writeIndex <= writeIndex_d;
      writeData <= writeData_d;
      overflowTrap <= overflowTrap_d;
      trapCause <= trapCause_d;
      retired <= retired_d;
    end
  end

  logic fire;
  always_comb fire = enable && instrValid;

  property p_trap_on_overflow;
    @(posedge clock) disable iff (!rstSync_q)
      fire && isTrapAdd && overflow |=> overflowTrap && !writeEnable;
  endproperty
  a_trap_on_overflow: assert property (p_trap_on_overflow) else $error("overflow not trapped"); // [RULE5]

  property p_cause;
    @(posedge clock) disable iff (!rstSync_q)
      overflowTrap |-> trapCause == `AWO_CAUSE_OVERFLOW && !writeEnable && !retired;
  endproperty
  a_cause: assert property (p_cause) else $error("bad cause or write with trap"); // [RULE10]

  property p_plain_no_trap;
    @(posedge clock) disable iff (!rstSync_q)
      fire && isPlainAdd |=> !overflowTrap && retired;
  endproperty
  a_plain_no_trap: assert property (p_plain_no_trap) else $error("plain add trapped"); // [RULE8]

  property p_zero_dest;
    @(posedge clock) disable iff (!rstSync_q)
      writeEnable |-> writeIndex != `AWO_ZERO_INDEX;
  endproperty
  a_zero_dest: assert property (p_zero_dest) else $error("write to register zero"); // [RULE9]

  property p_sign_ext;
    @(posedge clock) disable iff (!rstSync_q)
      writeEnable |-> writeData[XLEN-1:31] == '0 || writeData[XLEN-1:31] == '1;
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("result not sign-extended"); // [RULE6]

  property p_sum;
    @(posedge clock) disable iff (!rstSync_q)
      fire && (isTrapAdd || isPlainAdd) && dstIndex != `AWO_ZERO_INDEX && !(isTrapAdd && overflow)
      |=> writeEnable && writeData[31:0] == $past(rd.firstValue[31:0] + rd.secondValue[31:0]);
  endproperty
  a_sum: assert property (p_sum) else $error("wrong sum written"); // [RULE3]

  property p_overflow_def;
    @(posedge clock) disable iff (!rstSync_q)
      fire && isTrapAdd && rd.firstValue[31] == rd.secondValue[31]
      && wideSum[31] != rd.firstValue[31] |=> overflowTrap;
  endproperty
  a_overflow_def: assert property (p_overflow_def) else $error("missed overflow"); // [RULE4]

  property p_decode;
    @(posedge clock) disable iff (!rstSync_q)
      fire && instrWord[`AWO_OPC_HI:`AWO_OPC_LO] != `AWO_OPC_REGFMT
      |=> !writeEnable && !overflowTrap;
  endproperty
  a_decode: assert property (p_decode) else $error("acted on foreign opcode"); // [RULE1]

  property p_idle;
    @(posedge clock) disable iff (!rstSync_q)
      enable && !instrValid |=> !writeEnable && !retired && !overflowTrap;
  endproperty
  a_idle: assert property (p_idle) else $error("output without instruction"); // [RULE1]

  property p_freeze;
    @(posedge clock) disable iff (!rstSync_q)
      !enable |=> $stable(writeData) && $stable(retired) && $stable(overflowTrap)
      && $stable(writeEnable);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen"); // [RULE6]

  property p_index;
    @(posedge clock) disable iff (!rstSync_q)
      fire |=> writeIndex == $past(dstIndex);
  endproperty
  a_index: assert property (p_index) else $error("wrong destination index"); // [RULE1]

  property p_write_retires;
    @(posedge clock) disable iff (!rstSync_q)
      writeEnable |-> retired && !overflowTrap;
  endproperty
  a_write_retires: assert property (p_write_retires) else $error("write without retire"); // [RULE5]

  property p_dest_zero;
    @(posedge clock) disable iff (!rstSync_q)
      fire && isTrapAdd && !overflow && dstIndex == `AWO_ZERO_INDEX
      |=> retired && !writeEnable;
  endproperty
  a_dest_zero: assert property (p_dest_zero) else $error("zero destination mishandled"); // [RULE9]

  property p_cause_zero;
    @(posedge clock) disable iff (!rstSync_q)
      !overflowTrap |-> trapCause == '0;
  endproperty
  a_cause_zero: assert property (p_cause_zero) else $error("cause without trap"); // [RULE10]

  c_trap: cover property (@(posedge clock) disable iff (!rstSync_q) overflowTrap);
  c_write: cover property (@(posedge clock) disable iff (!rstSync_q) writeEnable);
  c_plain_wrap: cover property (@(posedge clock) disable iff (!rstSync_q)
    fire && isPlainAdd && overflow);
  c_freeze: cover property (@(posedge clock) disable iff (!rstSync_q) !enable && retired);
  c_dest_zero: cover property (@(posedge clock) disable iff (!rstSync_q)
    retired && !writeEnable);
endmodule

/* File: rtl/awo_map.svh */
// constants for the trapping word-add execute stage
`ifndef AWO_MAP_SVH
`define AWO_MAP_SVH
`define AWO_OPC_HI 31
`define AWO_OPC_LO 26
`define AWO_SRC1_HI 25
`define AWO_SRC1_LO 21
`define AWO_SRC2_HI 20
`define AWO_SRC2_LO 16
`define AWO_DST_HI 15
`define AWO_DST_LO 11
`define AWO_FUN_HI 5
`define AWO_FUN_LO 0
`define AWO_OPC_REGFMT 6'h00
`define AWO_FUN_TRAP_ADD 6'h20
`define AWO_FUN_PLAIN_ADD 6'h21
`define AWO_WORD_SIGN 31
`define AWO_CARRY_BIT 32
`define AWO_ZERO_INDEX 5'h00
`define AWO_CAUSE_OVERFLOW 5'h0c
`endif

/* File: rtl/awo_pkg.sv */
// types for the trapping word-add execute stage
package awo_pkg;
  typedef logic [4:0] awo_index_t;
  typedef logic [4:0] awo_cause_t;
endpackage

/* File: rtl/awo_read_port.sv */
// selects the two source words from the flat general register image
`timescale 1ns/1ps
`include "awo_map.svh"
module awo_read_port #(
  parameter int XLEN = 64
) (
  input wire logic [32*XLEN-1:0] regImage,
  awo_regread_if.port rd
);
  function automatic logic [XLEN-1:0] pick(input awo_pkg::awo_index_t idx,
                                           input logic [32*XLEN-1:0] img);
    // index zero always reads as zero, whatever the image holds
    if (idx == `AWO_ZERO_INDEX) begin
      pick = '0; // [RULE9]
    end else begin
      pick = img[idx*XLEN +: XLEN];
    end
  endfunction
  always_comb begin
    rd.firstValue = pick(rd.firstSourceIndex, regImage);
    rd.secondValue = pick(rd.secondSourceIndex, regImage);
  end
endmodule

/* File: rtl/awo_regread_if.sv */
// register file read pair between the stage and its read port module
`timescale 1ns/1ps
interface awo_regread_if #(parameter int XLEN = 64);
  awo_pkg::awo_index_t firstSourceIndex;
  awo_pkg::awo_index_t secondSourceIndex;
  logic [XLEN-1:0] firstValue;
  logic [XLEN-1:0] secondValue;
  modport stage (output firstSourceIndex, output secondSourceIndex,
                 input firstValue, input secondValue);
  modport port (input firstSourceIndex, input secondSourceIndex,
                output firstValue, output secondValue);
endinterface

/* File: testbench/awo_regfile_model.sv */
// register file model that feeds the flat register image to the stage
`timescale 1ns/1ps
module awo_regfile_model #(
  parameter int XLEN = 64
) (
  input wire logic clock,
  input wire logic setEn,
  input wire logic [4:0] setIdx,
  input wire logic [31:0] setWord,
  output logic [32*XLEN-1:0] regImage
);
  logic [XLEN-1:0] regs [32];
  // index zero keeps junk on purpose so the stage has to ignore it
  initial for (int i = 0; i < 32; i++) regs[i] = {XLEN{1'b1}};
  always @(posedge clock) begin
    if (setEn) regs[setIdx] <= {{(XLEN-32){setWord[31]}}, setWord};
  end
  always_comb begin
    for (int i = 0; i < 32; i++) regImage[i*XLEN +: XLEN] = regs[i];
  end
endmodule

/* File: testbench/tb_add_word_overflow_trap.sv */
// self-checking bench for the trapping word-add stage
`timescale 1ns/1ps
module tb_add_word_overflow_trap;
  typedef struct packed {
    logic [5:0] opc;
    logic [5:0] fun;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] d;
    logic [31:0] a;
    logic [31:0] b;
  } awo_row_t;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic enable = 1'b1;
  logic instrValid = 1'b0;
  logic [31:0] instrWord = 32'h0;
  logic setEn = 1'b0;
  logic [4:0] setIdx = 5'h00;
  logic [31:0] setWord = 32'h0;
  logic [2047:0] regImage;
  logic writeEnable, overflowTrap, retired;
  awo_pkg::awo_index_t writeIndex;
  awo_pkg::awo_cause_t trapCause;
  logic [63:0] writeData;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  awo_row_t rows [10] = '{
    '{6'h00, 6'h20, 5'h01, 5'h02, 5'h03, 32'h5, 32'h7},
    '{6'h00, 6'h20, 5'h04, 5'h05, 5'h06, 32'h7fffffff, 32'h1},
    '{6'h00, 6'h21, 5'h04, 5'h05, 5'h06, 32'h7fffffff, 32'h1},
    '{6'h00, 6'h20, 5'h07, 5'h08, 5'h09, 32'h80000000, 32'hffffffff},
    '{6'h00, 6'h20, 5'h00, 5'h02, 5'h0a, 32'h12345678, 32'h5},
    '{6'h00, 6'h20, 5'h01, 5'h02, 5'h00, 32'h3, 32'h4},
    '{6'h00, 6'h20, 5'h03, 5'h03, 5'h0b, 32'h1, 32'h40000000},
    '{6'h00, 6'h22, 5'h01, 5'h02, 5'h03, 32'h1, 32'h2},
    '{6'h01, 6'h20, 5'h01, 5'h02, 5'h03, 32'h1, 32'h2},
    '{6'h00, 6'h21, 5'h01, 5'h02, 5'h03, 32'h80000000, 32'h80000000}};
  awo_add_stage #(.XLEN(64)) DUT (.clock(clock), .reset_n(reset_n), .enable(enable),
    .instrValid(instrValid), .instrWord(instrWord), .regImage(regImage),
    .writeEnable(writeEnable), .writeIndex(writeIndex), .writeData(writeData),
    .overflowTrap(overflowTrap), .trapCause(trapCause), .retired(retired));
  awo_regfile_model #(.XLEN(64)) PART (.clock(clock), .setEn(setEn), .setIdx(setIdx),
    .setWord(setWord), .regImage(regImage));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input awo_row_t r, input bit hold);
    logic [32:0] sum;
    logic [31:0] a, b;
    logic legal, trap;
    @(negedge clock);
    setEn = 1'b1;
    setIdx = r.s1;
    setWord = r.a;
    @(negedge clock);
    setIdx = r.s2;
    setWord = r.b;
    @(negedge clock);
    setEn = 1'b0;
    instrValid = 1'b1;
    instrWord = {r.opc, r.s1, r.s2, r.d, 5'h00, r.fun};
    a = (r.s1 == 5'h00) ? 32'h0 : (r.s1 == r.s2) ? r.b : r.a;
    b = (r.s2 == 5'h00) ? 32'h0 : r.b;
    sum = {a[31], a} + {b[31], b};
    legal = r.opc == 6'h00 && (r.fun == 6'h20 || r.fun == 6'h21);
    trap = legal && r.fun == 6'h20 && sum[32] != sum[31];
    @(negedge clock);
    chk(overflowTrap, trap);
    chk(trapCause, trap ? 5'h0c : 5'h00);
    chk(retired, legal && !trap);
    chk(writeEnable, legal && !trap && r.d != 5'h00);
    if (legal && !trap && r.d != 5'h00) begin
      chk(writeIndex, r.d);
      chk(writeData, {{32{sum[31]}}, sum[31:0]});
    end
    instrValid = 1'b0;
    if (hold) enable = 1'b0;
  endtask
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    chk(retired, 1'b0);
    chk(overflowTrap, 1'b0);
    @(negedge clock);
    reset_n = 1'b1;
    foreach (rows[i]) run(rows[i], 1'b0);
    // a frozen stage must keep its last answer while enable is low
    run(rows[0], 1'b1);
    @(negedge clock);
    chk(retired, 1'b1);
    chk(writeData, 64'hc);
    enable = 1'b1;
    @(negedge clock);
    chk(retired, 1'b0);
    // reset in mid-run clears a standing trap at once, then the stage works again
    run(rows[1], 1'b0);
    reset_n = 1'b0;
    #1;
    chk(overflowTrap, 1'b0);
    chk(trapCause, 5'h00);
    @(negedge clock);
    reset_n = 1'b1;
    run(rows[0], 1'b0);
    tally_and_finish();
  end
endmodule
